// ===== logic/dddi_top.v
// ddr byte-lane input port, sample fifo and output code mapping
//
// Overview of operation
// RULE1: lane bytes are taken on both rising and falling data clock edges.
// RULE2: frame marker is taken on data clock rising edge, starts a frame.
// RULE3: a seen frame marker also resets the sample fifo pointers.
// RULE4: the source launches the frame marker edge-aligned with the lanes.
// RULE5: output sync strobe is taken on the converter clock rising edge.
// RULE6: a taken sync strobe resets the internal clock divider.
// RULE7: the controller holds the transmit gate high to pass data.
// RULE8: gate low forces the datapath to zero and ignores lane data.
// RULE9: code 0x0000 gives full-scale sink on the primary output.
// RULE10: code 0xFFFF gives zero sink on the primary output.
// RULE11: the complementary output is the inverse of the primary one.
// RULE12: channel b maps codes exactly as channel a does.
// RULE13: chip reset pin low applies a full chip reset.
// RULE14: external reference select high disables the internal reference.
// RULE15: two 16-bit samples go byte by byte, framed by the marker.
// RULE16: a configuration bit reverses the order of the eight lanes.
// RULE17: samples are written in data order and read in converter order.
//
// the data and converter clocks are sampled as levels on the core clock,
// so each must run well below a quarter of the core clock rate.
`include "dddi_defs.vh"

module dddi_top (
  // core clock and reset
  input  wire                      i_core_clk,
  input  wire                      i_sys_rst,
  // chip-level controls (pins)
  input  wire                      i_chip_reset_n,
  input  wire                      i_transmit_gate,
  input  wire                      i_lane_reverse,
  input  wire                      i_extref_select,
  // ddr input link (receiver already resolved the pairs)
  input  wire                      i_fwd_data_clock_pos,
  input  wire                      i_frame_marker_pos,
  input  wire [`DDDI_LANES-1:0]    i_lanes,
  // converter clock and output sync strobe
  input  wire                      i_converter_clock_pos,
  input  wire                      i_output_sync_strobe_pos,
  // converter core sink codes
  output reg  [`DDDI_SAMPLE_W-1:0] o_chan_a_primary_current,
  output reg  [`DDDI_SAMPLE_W-1:0] o_chan_a_complement_current,
  output reg  [`DDDI_SAMPLE_W-1:0] o_chan_b_primary_current,
  output reg  [`DDDI_SAMPLE_W-1:0] o_chan_b_complement_current,
  output reg                       o_sample_strobe,
  // clock divider state
  output wire [`DDDI_DIV_W-1:0]    o_divider_phase,
  // reference pin and internal reference control
  output wire                      o_reference_pin_o,
  output wire                      o_reference_pin_oe,
  output wire                      o_internal_ref_en,
  // fifo status
  output wire                      o_fifo_empty,
  output wire                      o_fifo_full,
  output reg                       o_fifo_overflow
);

  // synchronised pin levels
  wire                   chip_reset_n_s;
  wire                   gate_s;
  wire                   reverse_s;
  wire                   extref_s;
  wire                   dclk_s;
  wire                   frame_s;
  wire [`DDDI_LANES-1:0] lanes_s;
  wire                   cclk_s;
  wire                   ostr_s;

  dddi_sync #(
    .W       (1),
    .RST_VAL (1'b0)
  ) u_sync_rst (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_async    (i_chip_reset_n),
    .o_sync     (chip_reset_n_s)
  );

  dddi_sync #(
    .W       (3),
    .RST_VAL (1'b0)
  ) u_sync_ctl (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_async    ({i_transmit_gate, i_lane_reverse, i_extref_select}),
    .o_sync     ({gate_s, reverse_s, extref_s})
  );

  // clock, marker and lanes share one synchroniser so they stay aligned
  dddi_sync #(
    .W       (`DDDI_LANES + 2),
    .RST_VAL (1'b0)
  ) u_sync_link (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_async    ({i_fwd_data_clock_pos, i_frame_marker_pos, i_lanes}),
    .o_sync     ({dclk_s, frame_s, lanes_s})
  );

  dddi_sync #(
    .W       (2),
    .RST_VAL (1'b0)
  ) u_sync_conv (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_async    ({i_converter_clock_pos, i_output_sync_strobe_pos}),
    .o_sync     ({cclk_s, ostr_s})
  );

  // chip reset pin acts synchronously on top of the async system reset
  wire soft_rst = ~chip_reset_n_s; // RULE13

  // edge detection on the sampled clocks
  reg  dclk_q;
  reg  cclk_q;
  wire dclk_rise = dclk_s & ~dclk_q;
  wire dclk_fall = ~dclk_s & dclk_q;
  wire dclk_edge = dclk_rise | dclk_fall; // RULE1
  wire cclk_rise = cclk_s & ~cclk_q;

  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dclk_q <= 1'b0;
      cclk_q <= 1'b0;
    end else begin
      dclk_q <= dclk_s;
      cclk_q <= cclk_s;
    end
  end

  // optional lane order reversal
  reg [`DDDI_LANES-1:0] byte_in;
  integer               k;

  always @* begin
    byte_in = lanes_s;
    if (reverse_s) begin
      for (k = 0; k < `DDDI_LANES; k = k + 1) begin
        byte_in[k] = lanes_s[`DDDI_LANES-1-k]; // RULE16
      end
    end
  end

  // marker only counts on a rising edge; it is edge-aligned with lanes
  wire frame_seen = dclk_rise & frame_s; // RULE2 RULE4

  // byte assembly: a hi, a lo, b hi, b lo
  reg [`DDDI_BYTE_IDX_W-1:0] byte_idx_q;
  reg [`DDDI_WORD_W-1:0]     asm_q;
  reg                        asm_done_q;
  reg [`DDDI_BYTE_IDX_W-1:0] slot;

  always @* begin
    slot = byte_idx_q;
    if (frame_seen) begin
      slot = `DDDI_BYTE_A_HI; // RULE2
    end
  end

  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      byte_idx_q <= `DDDI_BYTE_A_HI;
      asm_q      <= `DDDI_WORD_ZERO;
      asm_done_q <= 1'b0;
    end else if (soft_rst | ~gate_s) begin
      // gate low: lanes ignored and partial frame dropped
      byte_idx_q <= `DDDI_BYTE_A_HI; // RULE8
      asm_q      <= `DDDI_WORD_ZERO; // RULE8
      asm_done_q <= 1'b0;
    end else begin
      asm_done_q <= 1'b0;
      if (dclk_edge) begin
        case (slot)
          `DDDI_BYTE_A_HI: asm_q[31:24] <= byte_in; // RULE15
          `DDDI_BYTE_A_LO: asm_q[23:16] <= byte_in; // RULE15
          `DDDI_BYTE_B_HI: asm_q[15:8]  <= byte_in; // RULE15
          default:         asm_q[7:0]   <= byte_in; // RULE15
        endcase
        byte_idx_q <= slot + 2'h1;
        asm_done_q <= (slot == `DDDI_BYTES_PER_FRM);
      end
    end
  end

  // clock divider on the converter clock, realigned by the strobe
  reg  [`DDDI_DIV_W-1:0] div_q;
  wire                   ostr_seen = cclk_rise & ostr_s; // RULE5

  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div_q <= `DDDI_DIV_RESET;
    end else if (soft_rst) begin
      div_q <= `DDDI_DIV_RESET;
    end else if (ostr_seen) begin
      div_q <= `DDDI_DIV_RESET; // RULE6
    end else if (cclk_rise) begin
      div_q <= div_q + 2'h1;
    end
  end

  assign o_divider_phase = div_q;

  // sample fifo: written on assembly, read once per divided period
  reg  [`DDDI_WORD_W-1:0] fifo_mem [0:`DDDI_FIFO_DEPTH-1];
  reg  [`DDDI_PTR_W-1:0]  wr_ptr_q;
  reg  [`DDDI_PTR_W-1:0]  rd_ptr_q;
  reg  [`DDDI_CNT_W-1:0]  count_q;
  wire                    full  = (count_q == `DDDI_FIFO_FULL);
  wire                    empty = (count_q == 4'h0);
  wire                    rd_slot = cclk_rise &
                                    (div_q == `DDDI_DIV_READ_PHASE);
  wire                    do_wr = asm_done_q & ~full; // RULE17
  wire                    do_rd = rd_slot & ~empty; // RULE17
  integer                 m;

  assign o_fifo_empty = empty;
  assign o_fifo_full  = full;

  // one clock drives both ends, so pointers need no gray crossing
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ptr_q        <= 3'h0;
      rd_ptr_q        <= 3'h0;
      count_q         <= 4'h0;
      o_fifo_overflow <= 1'b0;
      for (m = 0; m < `DDDI_FIFO_DEPTH; m = m + 1) begin
        fifo_mem[m] <= `DDDI_WORD_ZERO;
      end
    end else if (soft_rst | frame_seen | ~gate_s) begin
      // marker realigns pointers; stale samples are dropped
      wr_ptr_q        <= 3'h0; // RULE3
      rd_ptr_q        <= 3'h0; // RULE3
      count_q         <= 4'h0; // RULE3
      o_fifo_overflow <= 1'b0;
    end else begin
      if (do_wr) begin
        fifo_mem[wr_ptr_q] <= asm_q;
        wr_ptr_q           <= wr_ptr_q + 3'h1;
      end
      if (do_rd) begin
        rd_ptr_q <= rd_ptr_q + 3'h1;
      end
      if (do_wr & ~do_rd) begin
        count_q <= count_q + 4'h1;
      end else if (do_rd & ~do_wr) begin
        count_q <= count_q - 4'h1;
      end
      // a frame lost to a full fifo stays flagged until the next marker, gate low or chip reset
      if (asm_done_q & full) begin
        o_fifo_overflow <= 1'b1;
      end
    end
  end

  // output code mapping: offset binary, primary sinks full scale at zero
  wire [`DDDI_SAMPLE_W-1:0] code_a = fifo_mem[rd_ptr_q][31:16];
  wire [`DDDI_SAMPLE_W-1:0] code_b = fifo_mem[rd_ptr_q][15:0];

  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_chan_a_primary_current    <= `DDDI_CODE_ZERO;
      o_chan_a_complement_current <= `DDDI_CODE_ZERO;
      o_chan_b_primary_current    <= `DDDI_CODE_ZERO;
      o_chan_b_complement_current <= `DDDI_CODE_ZERO;
      o_sample_strobe             <= 1'b0;
    end else if (soft_rst | ~gate_s) begin
      // zero datapath: core sees code 0 on both channels
      o_chan_a_primary_current    <= ~`DDDI_CODE_ZERO; // RULE8 RULE9
      o_chan_a_complement_current <= `DDDI_CODE_ZERO; // RULE8 RULE11
      o_chan_b_primary_current    <= ~`DDDI_CODE_ZERO; // RULE8 RULE12
      o_chan_b_complement_current <= `DDDI_CODE_ZERO; // RULE8 RULE12
      o_sample_strobe             <= 1'b0;
    end else begin
      o_sample_strobe <= do_rd;
      if (do_rd) begin
        // sink magnitude: primary falls as code rises
        o_chan_a_primary_current    <= ~code_a; // RULE9 RULE10
        o_chan_a_complement_current <= code_a; // RULE11
        o_chan_b_primary_current    <= ~code_b; // RULE12
        o_chan_b_complement_current <= code_b; // RULE12
      end
    end
  end

  // reference: internal source drives the pin unless external selected
  reg extref_q;

  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      extref_q <= `DDDI_EXTREF_DEFAULT;
    end else if (soft_rst) begin
      extref_q <= `DDDI_EXTREF_DEFAULT;
    end else begin
      extref_q <= extref_s;
    end
  end

  assign o_internal_ref_en  = ~extref_q; // RULE14
  assign o_reference_pin_oe = ~extref_q; // RULE14
  assign o_reference_pin_o  = ~extref_q;

endmodule

// ===== logic/dddi_defs.vh
// constants for the dual converter ddr input port
`ifndef DDDI_DEFS_VH
`define DDDI_DEFS_VH

`define DDDI_LANES          8
`define DDDI_SAMPLE_W       16
`define DDDI_WORD_W         32
`define DDDI_FIFO_DEPTH     8
`define DDDI_PTR_W          3
`define DDDI_CNT_W          4
`define DDDI_BYTE_IDX_W     2
`define DDDI_BYTES_PER_FRM  2'h3
`define DDDI_BYTE_A_HI      2'h0
`define DDDI_BYTE_A_LO      2'h1
`define DDDI_BYTE_B_HI      2'h2
`define DDDI_BYTE_B_LO      2'h3
`define DDDI_DIV_W          2
`define DDDI_DIV_RESET      2'h0
`define DDDI_DIV_READ_PHASE 2'h3
`define DDDI_CODE_ZERO      16'h0000
`define DDDI_WORD_ZERO      32'h00000000
`define DDDI_FIFO_FULL      4'h8
`define DDDI_EXTREF_DEFAULT 1'b0

`endif

// ===== logic/dddi_sync.v
// two flip-flop synchroniser for pins from outside the core clock domain
module dddi_sync #(
  parameter W       = 1,
  parameter RST_VAL = 1'b0
) (
  // clock and reset
  input  wire         i_core_clk,
  input  wire         i_sys_rst,
  // asynchronous input and its synchronised copy
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // the first stage is read only by the second stage
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta_q <= {W{RST_VAL}};
      sync_q <= {W{RST_VAL}};
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

// ===== sim/dddi_source_model.sv
// source logic model driving the ddr lanes, marker and data clock
module dddi_source_model (
  // pacing clock
  input  logic       i_core_clk,
  // ddr link toward the port
  output logic       o_fwd_data_clock_pos,
  output logic       o_frame_marker_pos,
  output logic [7:0] o_lanes
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_fwd_data_clock_pos = 1'b0;
    o_frame_marker_pos = 1'b0;
    o_lanes = 8'h00;
  end
  // bytes move mid half-period: 3 settled cycles either side of an edge;
  // n must be even so the data clock rests low between frames;
  // bytes past the fourth repeat the word with no marker
  task automatic send(input logic [31:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge i_core_clk);
      o_lanes = w[31 - 8 * (i % 4) -: 8];
      o_frame_marker_pos = (i == 0);
      repeat (3) @(negedge i_core_clk);
      o_fwd_data_clock_pos = ~o_fwd_data_clock_pos;
      repeat (2) @(negedge i_core_clk);
    end
    // released lanes show the inverse so stale bytes cannot pass
    @(negedge i_core_clk);
    o_lanes = ~o_lanes;
    o_frame_marker_pos = 1'b0;
  endtask
endmodule

// ===== sim/dddi_top_monitor.sv
// concurrent checks on the ddr input port outputs
module dddi_top_monitor (
  // clock, reset and pins
  input logic        i_core_clk,
  input logic        i_sys_rst,
  input logic        i_chip_reset_n,
  input logic        i_transmit_gate,
  input logic        i_extref_select,
  input logic        i_converter_clock_pos,
  input logic        i_output_sync_strobe_pos,
  // outputs watched
  input logic [15:0] o_chan_a_primary_current,
  input logic [15:0] o_chan_a_complement_current,
  input logic [15:0] o_chan_b_primary_current,
  input logic [15:0] o_chan_b_complement_current,
  input logic        o_sample_strobe,
  input logic [1:0]  o_divider_phase,
  input logic        o_reference_pin_oe,
  input logic        o_internal_ref_en,
  input logic        o_fifo_empty
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // saturates so a long strobe never wraps back to zero
  logic [4:0] hold_q;
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
    if (i_sys_rst) hold_q <= 5'h00;
    else if (!i_output_sync_strobe_pos) hold_q <= 5'h00;
    else if (hold_q != 5'h1F) hold_q <= hold_q + 5'h01;
  chk_a_inverse: assert property (
    !$past(i_sys_rst) |->
    o_chan_a_complement_current == ~o_chan_a_primary_current)
    else $error("chan a not inverse");
  chk_b_inverse: assert property (
    !$past(i_sys_rst) |->
    o_chan_b_complement_current == ~o_chan_b_primary_current)
    else $error("chan b not inverse");
  chk_gate_zero: assert property (
    !i_transmit_gate [*4] |=> o_fifo_empty && !o_sample_strobe &&
    o_chan_a_primary_current == 16'hFFFF)
    else $error("gate low passed data");
  chk_chip_reset: assert property (
    !i_chip_reset_n [*4] |=> o_fifo_empty && o_divider_phase == 2'h0 &&
    o_chan_b_primary_current == 16'hFFFF)
    else $error("chip reset not applied");
  chk_ref_ext: assert property (
    (i_extref_select && i_chip_reset_n) [*5] |=>
    !o_reference_pin_oe && !o_internal_ref_en)
    else $error("internal reference still on");
  chk_div_idle: assert property (
    (!i_converter_clock_pos && i_chip_reset_n) [*4] |=>
    $stable(o_divider_phase))
    else $error("divider moved without converter edge");
  chk_sync_zero: assert property (
    hold_q >= 5'h10 |-> o_divider_phase == 2'h0)
    else $error("sync strobe did not reset divider");
  chk_read_pulse: assert property (
    o_sample_strobe |-> !$past(o_fifo_empty) ##1 !o_sample_strobe)
    else $error("bad read strobe");
endmodule

bind dddi_top dddi_top_monitor mon (.*);

// ===== sim/dual_dac_ddr_input_port_tb.sv
// self-checking bench for the ddr input port
module dual_dac_ddr_input_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_core_clk, i_sys_rst, i_chip_reset_n, i_transmit_gate;
  logic        i_lane_reverse, i_extref_select, i_converter_clock_pos;
  logic        i_output_sync_strobe_pos, i_fwd_data_clock_pos;
  logic        i_frame_marker_pos, o_sample_strobe, o_fifo_empty;
  logic        o_fifo_full, o_fifo_overflow;
  logic        o_reference_pin_o, o_reference_pin_oe, o_internal_ref_en;
  logic [7:0]  i_lanes;
  logic [1:0]  o_divider_phase;
  logic [15:0] o_chan_a_primary_current, o_chan_a_complement_current;
  logic [15:0] o_chan_b_primary_current, o_chan_b_complement_current;
  logic [15:0] seed = 16'hFEFE;
  logic [31:0] exp_q [$];
  logic [31:0] e;
  int          bad_count = 0;
  int          total_checks = 0;
  dddi_top dut (.*);
  dddi_source_model src (.i_core_clk(i_core_clk),
    .o_fwd_data_clock_pos(i_fwd_data_clock_pos),
    .o_frame_marker_pos(i_frame_marker_pos), .o_lanes(i_lanes));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // lane reversal mirrors the bits inside each byte
  function automatic logic [31:0] flip(input logic [31:0] w);
    for (int i = 0; i < 32; i++) flip[i] = w[i - 2 * (i % 8) + 7];
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    total_checks++;
    if (got !== want) begin
      bad_count++;
      $display("unexpected %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // reads come only at divider phase 3, so allow a few converter periods
  task automatic frame(input logic [31:0] w, input logic rev);
    i_lane_reverse = rev;
    exp_q.push_back(rev ? flip(w) : w);
    src.send(w, 4);
    for (int t = 0; t < 90 && exp_q.size() != 0; t++) tick(1);
    chk(16'(exp_q.size()), 16'h0000);
  endtask
  // a read with nothing queued compares against unknown and fails
  always @(negedge i_core_clk) begin
    if (o_sample_strobe === 1'b1) begin
      e = exp_q.size() != 0 ? exp_q.pop_front() : 32'hX;
      chk(o_chan_a_primary_current, ~e[31:16]);
      chk(o_chan_a_complement_current, e[31:16]);
      chk(o_chan_b_primary_current, ~e[15:0]);
      chk(o_chan_b_complement_current, e[15:0]);
    end
  end
  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  initial begin
    i_converter_clock_pos = 1'b0;
    forever begin
      tick(4);
      i_converter_clock_pos = ~i_converter_clock_pos;
    end
  end
  initial begin
    {i_sys_rst, i_chip_reset_n, i_transmit_gate, i_lane_reverse} = 4'hC;
    i_extref_select = 1'b0;
    i_output_sync_strobe_pos = 1'b0;
    tick(12);
    i_sys_rst = 1'b0;
    tick(6);
    chk(o_chan_a_primary_current, 16'hFFFF);
    chk(16'(o_reference_pin_oe), 16'h0001);
    i_transmit_gate = 1'b1;
    tick(6);
    frame(32'h0000FFFF, 1'b0);
    src.send(32'hA55A0000, 2);
    frame(32'h12345678, 1'b0);
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      frame({seed, lfsr(seed)}, k[0]);
    end
    i_transmit_gate = 1'b0;
    tick(6);
    src.send(32'hFFFF0000, 4);
    tick(60);
    chk(o_chan_b_primary_current, 16'hFFFF);
    i_transmit_gate = 1'b1;
    i_output_sync_strobe_pos = 1'b1;
    tick(24);
    chk(16'(o_divider_phase), 16'h0000);
    // strobe held high keeps the divider off the read phase, so nine
    // words, only the first one marked, fill the fifo and the last one is lost
    src.send(32'h3C3CC3C3, 36);
    tick(4);
    chk(16'(o_fifo_full), 16'h0001);
    chk(16'(o_fifo_overflow), 16'h0001);
    src.send(32'hA55A0000, 2);
    chk(16'({o_fifo_full, o_fifo_empty}), 16'h0001);
    chk(16'(o_fifo_overflow), 16'h0000);
    i_output_sync_strobe_pos = 1'b0;
    i_extref_select = 1'b1;
    tick(6);
    chk(16'({o_reference_pin_oe, o_internal_ref_en}), 16'h0000);
    i_extref_select = 1'b0;
    i_chip_reset_n = 1'b0;
    tick(6);
    chk(16'(o_fifo_empty), 16'h0001);
    chk(o_chan_a_complement_current, 16'h0000);
    chk(16'(o_reference_pin_o), 16'h0001);
    i_chip_reset_n = 1'b1;
    tick(6);
    frame(32'h8001FF00, 1'b1);
    summarize();
  end
  initial begin
    tick(4000);
    bad_count++;
    summarize();
  end
endmodule
